/* inc/fsm_params.svh */
// constants for the fault state manager
`ifndef FSM_PARAMS_SVH
`define FSM_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define FSM_CLK_HZ 10000000
`define FSM_RETRY_MS 20
`define FSM_RETRY_CYC ((`FSM_CLK_HZ / 1000) * `FSM_RETRY_MS)
`define FSM_CRC_RETRY_MAX 3
`define FSM_POR_CYC 16
// ----------------------------------------
// fault vector widths
// ----------------------------------------
`define FSM_INIT_W 6
`define FSM_RT1_W 10
`define FSM_RT2_W 2
`endif

/* inc/fsm_pkg.sv */
// types for the fault state manager
package fsm_pkg;
	// operating states, one-hot
	typedef enum logic [4:0] {
		FSM_IDLE = 5'h01,
		FSM_DIAG = 5'h02,
		FSM_NORM = 5'h04,
		FSM_FLT = 5'h08,
		FSM_DIS = 5'h10
	} fsm_state_t;
endpackage

/* logic/fsm_pin_watch.sv */
// pin watcher: latches a pin level and flags any later change
`include "fsm_params.svh"
module fsm_pin_watch (
	input wire logic clk_i, // clock
	input wire logic srst_i, // sync reset
	input wire logic latch_i, // capture pin level now
	input wire logic arm_i, // compare enabled
	input wire logic pin_i, // watched pin
	output logic chg_o // pin differs from latched level
);
	logic ref_q; // latched level
	logic ref_d;
	logic armd_q; // a level has been captured
	logic armd_d;
	logic chg_q;
	logic chg_d;

	// next-state: capture, then compare
	always_comb begin
		ref_d = ref_q;
		armd_d = armd_q;
		chg_d = 1'b0;
		if (latch_i) begin
			ref_d = pin_i;
			armd_d = 1'b1;
		end else if (arm_i && armd_q) begin
			chg_d = (pin_i != ref_q);
		end
	end

	// registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ref_q <= 1'b0;
			armd_q <= 1'b0;
			chg_q <= 1'b0;
		end else begin
			ref_q <= ref_d;
			armd_q <= armd_d;
			chg_q <= chg_d;
		end
	end
	assign chg_o = chg_q;
endmodule // fsm_pin_watch

/* logic/fsm_fault_manager.sv */
// operating-state controller: sequencing, fault routing, enables, output tri-state
// Operation
// - supplies good: idle, reset, then diagnostics
// - diagnostics pass goes normal, else by class
// - outputs show fault until checks done
// - normal: oscillator, front end, gain, outputs on
// - recoverable run-time fault: normal to fault
// - critical run-time fault: straight to disabled
// - initialization failure: disabled, fault shown
// - supply undervoltage holds reset, then restart
// - fault: oscillator, front end off, outputs tri-state
// - thermal or overvoltage: wait until cause gone
// - other recoverable faults retry via diagnostics
// - disabled from diag/normal/fault, everything off
// - after 20 ms disabled, retry diagnostics
// - memory CRC: three retries, then stay disabled
// - power cycle returns disabled to idle
// - idle, fault, disabled: outputs high impedance
// - latch test pin at init, change critical
// - fault state keeps critical checks, go disabled
`include "fsm_params.svh"
module fsm_fault_manager
	import fsm_pkg::*;
#(
	parameter int unsigned RETRY_CYC = `FSM_RETRY_CYC, // disabled dwell before retry
	parameter int unsigned CRC_RETRY_MAX = `FSM_CRC_RETRY_MAX, // memory CRC retries
	parameter int unsigned POR_CYC = `FSM_POR_CYC // internal reset pulse length
) (
	input wire logic clk_i, // 10 MHz clock
	input wire logic srst_i, // sync reset, active high
	input wire logic supply_reg_ok_i, // regulated supply above limit
	input wire logic supply_core_ok_i, // core supply above limit
	input wire logic diag_done_i, // diagnostics sequence finished
	input wire logic [`FSM_INIT_W-1:0] init_fail_i, // init faults, bit0 memory CRC
	input wire logic [`FSM_RT1_W-1:0] rt1_fault_i, // recoverable faults, bits 1:0 forcing
	input wire logic [`FSM_RT2_W-1:0] rt2_fault_i, // bit0 redundancy, bit1 register CRC
	input wire logic test_mode_pin_i, // test mode pin level
	input wire logic test_output_pin_i, // test output pin level
	input wire logic gain_mode_select_pin_i, // gain mode pin level
	input wire logic [3:0] drive_i, // analog output drive values
	output logic por_o, // internal power-on reset pulse
	output logic diag_run_o, // diagnostics sequence running
	output logic osc_en_o, // coil oscillator enable
	output logic afe_en_o, // analog front end enable
	output logic gain_en_o, // gain control enable
	output logic [3:0] analog_output_pair_o, // output values
	output logic [3:0] analog_output_pair_oe_o, // output enables, high drives
	output logic fault_ind_o, // fault being indicated
	output logic crc_lock_o, // memory CRC retries exhausted
	output logic [4:0] state_o // current state code
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	if (RETRY_CYC < 1 || RETRY_CYC > 32'hFFFFFF) begin : g_chk_retry
		$error("retry count out of range");
	end
	if (CRC_RETRY_MAX < 1 || CRC_RETRY_MAX > 15) begin : g_chk_crc
		$error("crc retry limit out of range");
	end
	if (POR_CYC < 1 || POR_CYC > 255) begin : g_chk_por
		$error("por length out of range");
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	fsm_state_t st_q; // current state
	fsm_state_t st_d;
	logic [23:0] tmr_q; // disabled dwell timer
	logic [23:0] tmr_d;
	logic [7:0] por_q; // power-on reset counter
	logic [7:0] por_d;
	logic [3:0] crc_cnt_q; // memory CRC retry count
	logic [3:0] crc_cnt_d;
	logic crc_cause_q; // disabled entered for memory CRC
	logic crc_cause_d;
	logic diag_first_q; // first cycle of diagnostics
	logic tm_chg; // test mode pin changed
	logic to_chg; // test output pin changed
	logic gm_chg; // gain pin changed
	logic pins_arm; // pin comparison active
	logic supply_ok; // both supplies good
	logic crit; // any critical fault
	logic rec; // any recoverable fault
	logic forcing; // thermal or overvoltage present
	logic osc_d; // registered output next values
	logic afe_d;
	logic gain_d;
	logic [3:0] out_d;
	logic [3:0] oe_d;
	logic flt_d;

	// wrap-safe compare of a counter against a limit
	function automatic logic reached(input logic [23:0] cnt, input int unsigned lim);
		reached = (cnt >= 24'(lim - 1));
	endfunction

	// ----------------------------------------
	// pin watchers
	// ----------------------------------------
	assign pins_arm = (st_q == FSM_NORM) || (st_q == FSM_FLT);
	fsm_pin_watch u_tm (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.latch_i(diag_first_q),
		.arm_i(pins_arm),
		.pin_i(test_mode_pin_i),
		.chg_o(tm_chg)
	);
	fsm_pin_watch u_to (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.latch_i(diag_first_q),
		.arm_i(pins_arm),
		.pin_i(test_output_pin_i),
		.chg_o(to_chg)
	);
	fsm_pin_watch u_gm (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.latch_i(diag_first_q),
		.arm_i(pins_arm),
		.pin_i(gain_mode_select_pin_i),
		.chg_o(gm_chg)
	);

	// fault classification
	assign supply_ok = supply_reg_ok_i && supply_core_ok_i;
	assign crit = (|rt2_fault_i) || tm_chg || to_chg || gm_chg;
	assign rec = |rt1_fault_i;
	assign forcing = |rt1_fault_i[1:0]; // thermal, regulator overvoltage

	// ----------------------------------------
	// state machine next values
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		tmr_d = 24'h000000;
		por_d = por_q;
		crc_cnt_d = crc_cnt_q;
		crc_cause_d = crc_cause_q;
		case (st_q)
			// power-on reset pulse, then diagnostics
			FSM_IDLE: begin
				if (por_q == 8'(POR_CYC - 1)) begin
					st_d = FSM_DIAG;
				end else begin
					por_d = por_q + 8'h01;
				end
			end
			// self checks; route by class once done
			FSM_DIAG: begin
				if (diag_done_i) begin
					if (|init_fail_i) begin
						st_d = FSM_DIS;
						crc_cause_d = init_fail_i[0];
					end else if (crit) begin
						st_d = FSM_DIS;
						crc_cause_d = 1'b0;
					end else if (rec) begin
						st_d = FSM_FLT;
					end else begin
						st_d = FSM_NORM;
					end
				end
			end
			// running; critical faults beat recoverable
			FSM_NORM: begin
				if (crit) begin
					st_d = FSM_DIS;
					crc_cause_d = 1'b0;
				end else if (rec) begin
					st_d = FSM_FLT;
				end
			end
			// wait out forcing faults, retry others
			FSM_FLT: begin
				if (crit) begin
					st_d = FSM_DIS;
					crc_cause_d = 1'b0;
				end else if (forcing) begin
					st_d = FSM_FLT; // no retry while the cause is present
				end else begin
					st_d = FSM_DIAG;
				end
			end
			// dwell, then retry unless CRC retries exhausted
			FSM_DIS: begin
				if (crc_cause_q && (crc_cnt_q >= 4'(CRC_RETRY_MAX))) begin
					st_d = FSM_DIS;
				end else if (reached(tmr_q, RETRY_CYC)) begin
					st_d = FSM_DIAG;
					if (crc_cause_q) begin
						crc_cnt_d = crc_cnt_q + 4'h1;
					end
				end else begin
					tmr_d = tmr_q + 24'h000001;
				end
			end
			default: begin
				st_d = FSM_IDLE;
			end
		endcase
		// supply loss restarts from idle; count kept only across it here
		if (!supply_ok) begin
			st_d = FSM_IDLE;
			por_d = 8'h00;
			tmr_d = 24'h000000;
		end
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q <= FSM_IDLE;
			tmr_q <= 24'h000000;
			por_q <= 8'h00;
			crc_cnt_q <= 4'h0;
			crc_cause_q <= 1'b0;
			diag_first_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			por_q <= por_d;
			crc_cnt_q <= crc_cnt_d;
			crc_cause_q <= crc_cause_d;
			diag_first_q <= (st_d == FSM_DIAG) && (st_q != FSM_DIAG);
		end
	end

	// ----------------------------------------
	// output next values
	// ----------------------------------------
	always_comb begin
		osc_d = 1'b0;
		afe_d = 1'b0;
		gain_d = 1'b0;
		out_d = 4'h0;
		oe_d = 4'h0; // safe states tri-state
		flt_d = 1'b1;
		case (st_d)
			// checks need the signal path; outputs held off until done
			FSM_DIAG: begin
				osc_d = 1'b1;
				afe_d = 1'b1;
				gain_d = 1'b1;
			end
			// fully active
			FSM_NORM: begin
				osc_d = 1'b1;
				afe_d = 1'b1;
				gain_d = 1'b1;
				out_d = drive_i;
				oe_d = 4'hF;
				flt_d = 1'b0;
			end
			// fault and disabled keep everything off
			FSM_FLT: begin
				flt_d = 1'b1;
			end
			FSM_DIS: begin
				flt_d = 1'b1;
			end
			default: begin
				flt_d = 1'b1;
			end
		endcase
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			osc_en_o <= 1'b0;
			afe_en_o <= 1'b0;
			gain_en_o <= 1'b0;
			analog_output_pair_o <= 4'h0;
			analog_output_pair_oe_o <= 4'h0;
			fault_ind_o <= 1'b1;
			por_o <= 1'b0;
			diag_run_o <= 1'b0;
			crc_lock_o <= 1'b0;
			state_o <= 5'h01;
		end else begin
			osc_en_o <= osc_d;
			afe_en_o <= afe_d;
			gain_en_o <= gain_d;
			analog_output_pair_o <= out_d;
			analog_output_pair_oe_o <= oe_d;
			fault_ind_o <= flt_d;
			por_o <= (st_d == FSM_IDLE);
			diag_run_o <= (st_d == FSM_DIAG);
			crc_lock_o <= (st_d == FSM_DIS) && crc_cause_d && (crc_cnt_d >= 4'(CRC_RETRY_MAX));
			state_o <= st_d;
		end
	end
endmodule // fsm_fault_manager

/* sim/fsm_host_model.sv */
// host side model: pin levels as seen through the pull resistors
module fsm_host_model #(
	parameter logic [3:0] PULL = 4'hA // pull level per pin
) (
	input wire logic [3:0] out_i, // device pin values
	input wire logic [3:0] oe_i, // device pin enables
	output logic [3:0] lvl_o // level the host samples
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released pin settles to its pull level
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			lvl_o[b] = oe_i[b] ? out_i[b] : PULL[b];
		end
	end
endmodule // fsm_host_model

/* sim/fsm_fault_manager_asserts.sv */
// assertion checker for the fault state manager
`include "fsm_params.svh"
module fsm_fm_asserts
	import fsm_pkg::*;
#(
	parameter int unsigned RETRY_CYC = 20, // disabled dwell
	parameter int unsigned CRC_RETRY_MAX = 3, // crc retries
	parameter int unsigned POR_CYC = 2 // reset pulse
) (
	input wire logic clk_i, // clock
	input wire logic srst_i, // sync reset
	input wire logic supply_reg_ok_i, // supply good
	input wire logic supply_core_ok_i, // supply good
	input wire logic [`FSM_INIT_W-1:0] init_fail_i, // init faults
	input wire logic [`FSM_RT1_W-1:0] rt1_fault_i, // recoverable
	input wire logic [`FSM_RT2_W-1:0] rt2_fault_i, // critical
	input wire logic diag_run_o, // checks running
	input wire logic osc_en_o, // oscillator on
	input wire logic afe_en_o, // front end on
	input wire logic gain_en_o, // gain on
	input wire logic [3:0] analog_output_pair_oe_o, // pin enables
	input wire logic fault_ind_o, // fault shown
	input wire logic crc_lock_o, // retries spent
	input wire logic [4:0] state_o // state code
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic ok, sd, sn, sf, sx; // supplies good, state decodes
	logic [31:0] dis_q, dis_d; // cycles spent disabled
	assign ok = supply_reg_ok_i && supply_core_ok_i;
	assign sd = state_o == FSM_DIAG;
	assign sn = state_o == FSM_NORM;
	assign sf = state_o == FSM_FLT;
	assign sx = state_o == FSM_DIS;
	// dwell counter, cleared outside disabled
	always_comb begin
		dis_d = (sx && !srst_i) ? dis_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk_i) begin
		dis_q <= dis_d;
	end
	diag_flag_a: assert property (
		sd |-> fault_ind_o && !(|analog_output_pair_oe_o) && diag_run_o) else $error("diag out");
	norm_on_a: assert property (
		sn |-> &analog_output_pair_oe_o && !fault_ind_o && osc_en_o && afe_en_o && gain_en_o)
		else $error("normal out");
	rec_flt_a: assert property (
		sn && ok && !(|rt2_fault_i) && |rt1_fault_i |=> sf) else $error("no fault");
	crit_dis_a: assert property (
		(sn || sf) && ok && |rt2_fault_i |=> sx) else $error("no disable");
	uv_idle_a: assert property (!ok |=> state_o == FSM_IDLE) else $error("no idle");
	safe_off_a: assert property (
		sf || sx |-> !(|analog_output_pair_oe_o) && fault_ind_o && !osc_en_o && !afe_en_o)
		else $error("safe out");
	flt_next_a: assert property (
		sf && ok && !(|rt2_fault_i) |=> state_o == ($past(|rt1_fault_i[1:0]) ? FSM_FLT : FSM_DIAG))
		else $error("fault exit");
	dis_dwell_a: assert property (
		sx ##1 sd |-> $past(dis_q) inside {[RETRY_CYC - 2:RETRY_CYC]}) else $error("dwell");
	crc_lock_a: assert property (
		crc_lock_o && ok |=> sx && crc_lock_o) else $error("lock left");
	cover property (sn);
	cover property (sf ##1 sd);
	cover property (crc_lock_o);
endmodule // fsm_fm_asserts
bind fsm_fault_manager fsm_fm_asserts #(.RETRY_CYC(RETRY_CYC), .CRC_RETRY_MAX(CRC_RETRY_MAX),
	.POR_CYC(POR_CYC)) u_chk (.clk_i, .srst_i, .supply_reg_ok_i, .supply_core_ok_i, .init_fail_i,
	.rt1_fault_i, .rt2_fault_i, .diag_run_o, .osc_en_o, .afe_en_o, .gain_en_o,
	.analog_output_pair_oe_o, .fault_ind_o, .crc_lock_o, .state_o);

/* sim/fault_state_manager_tb.sv */
// self-checking bench for the fault state manager
`include "fsm_params.svh"
module fault_state_manager_tb
	import fsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int R = 20; // disabled dwell in sim
	logic clk_i, srst, rg, cr, done, tm, tp, gm; // drives
	logic [5:0] ifl; // init faults
	logic [9:0] r1; // recoverable faults
	logic [1:0] r2; // critical faults
	logic [3:0] drv, aout, oe, lvl; // output path
	logic [4:0] st, m_st; // design and model state
	logic por, drun, osc, afe, gain, fi, lock; // status
	int fail_count = 0, cmp_count = 0, nc, m_crc, cause, pc = 0;
	int unsigned rs = 72204;
	wire [9:0] outs = {por, oe, fi, osc, afe, gain, drun};
	fsm_fault_manager #(.RETRY_CYC(R), .CRC_RETRY_MAX(3), .POR_CYC(2)) dut (
		.clk_i(clk_i), .srst_i(srst), .supply_reg_ok_i(rg), .supply_core_ok_i(cr),
		.diag_done_i(done), .init_fail_i(ifl), .rt1_fault_i(r1), .rt2_fault_i(r2),
		.test_mode_pin_i(tm), .test_output_pin_i(tp), .gain_mode_select_pin_i(gm),
		.drive_i(drv), .por_o(por), .diag_run_o(drun), .osc_en_o(osc), .afe_en_o(afe),
		.gain_en_o(gain), .analog_output_pair_o(aout), .analog_output_pair_oe_o(oe),
		.fault_ind_o(fi), .crc_lock_o(lock), .state_o(st));
	fsm_host_model #(.PULL(4'hA)) host (.out_i(aout), .oe_i(oe), .lvl_o(lvl));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	function automatic logic [3:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[3:0];
	endfunction
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task automatic go(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// expected {por, enables, fault, osc, afe, gain, diag} per state
	function automatic logic [9:0] exp_o(input logic [4:0] s);
		case (s)
			FSM_IDLE: return 10'h210;
			FSM_DIAG: return 10'h01F;
			FSM_NORM: return 10'h1EE;
			default: return 10'h010;
		endcase
	endfunction
	// reference next state from the present inputs
	function automatic logic [4:0] nxt();
		if (!(rg && cr)) return FSM_IDLE;
		case (m_st)
			FSM_IDLE: return FSM_DIAG;
			FSM_DIAG: return (|{ifl, r2}) ? FSM_DIS : (|r1 ? FSM_FLT : FSM_NORM);
			FSM_NORM: return (|r2 || pc != 0) ? FSM_DIS : FSM_FLT;
			FSM_FLT: return |r2 ? FSM_DIS : (|r1[1:0] ? FSM_FLT : FSM_DIAG);
			default: return (cause != 0 && m_crc >= 3) ? FSM_DIS : FSM_DIAG;
		endcase
	endfunction
	// wait bounded for a state change, then compare with the model
	task automatic wt(input int mx);
		logic [4:0] e;
		e = nxt();
		nc = 0;
		while (st === m_st && nc < mx) begin
			go(1);
			nc++;
		end
		if (m_st == FSM_DIAG && e == FSM_DIS) cause = ifl[0];
		if (m_st == FSM_DIS && e == FSM_DIAG && cause != 0) m_crc++;
		chk(st, e);
		chk(outs, exp_o(e));
		m_st = e;
	endtask
	task automatic back();
		wt(R + 5);
		chk(nc >= R - 1 && nc <= R + 1, 1'b1);
		wt(5);
	endtask
	task automatic rst();
		srst = 1'b1;
		go(4);
		srst = 1'b0;
		{m_crc, cause} = 0;
		m_st = FSM_IDLE;
		chk(st, FSM_IDLE);
	endtask
	task automatic finish_test();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		finish_test();
	end
	initial begin
		{srst, rg, cr, done, tm, tp, gm} = 7'h78;
		{ifl, r1, r2, drv} = 22'h0;
		rst();
		done = 1'b0;
		wt(20);
		go(5);
		chk(outs, 10'h01F);
		done = 1'b1;
		wt(5);
		repeat (4) begin
			drv = xs();
			go(2);
			chk(lvl, drv);
		end
		for (int b = 0; b < 10; b++) begin
			r1 = 10'h1 << b;
			wt(5);
			chk(lvl, 4'hA);
			if (b < 2) go(10);
			if (b < 2) chk(st, FSM_FLT);
			if (b == 1) begin
				r2 = 2'h1;
				wt(5);
				{r1, r2} = 12'h0;
				back();
			end else begin
				r1 = 10'h0;
				wt(5);
				wt(5);
			end
		end
		for (int b = 0; b < 2; b++) begin
			r2 = 2'h1 << b;
			wt(5);
			r2 = 2'h0;
			back();
		end
		for (int b = 0; b < 3; b++) begin
			{tm, tp, gm} = {tm, tp, gm} ^ (3'h4 >> b);
			pc = 1;
			wt(5);
			pc = 0;
			back();
		end
		r2 = 2'h1;
		wt(5);
		r2 = 2'h0;
		for (int b = 1; b < 7; b++) begin
			ifl = 6'h1 << (b % 6);
			back();
		end
		repeat (3) back();
		wt(3 * R);
		chk(lock, 1'b1);
		rg = 1'b0;
		wt(5);
		rg = 1'b1;
		wt(10);
		wt(5);
		wt(3 * R);
		rst();
		wt(20);
		wt(5);
		back();
		ifl = 6'h0;
		back();
		cr = 1'b0;
		wt(5);
		cr = 1'b1;
		wt(10);
		wt(5);
		finish_test();
	end
endmodule // fault_state_manager_tb
